// ===== logic/dss_defines.vh
// Object indices, field positions, reset values and codes of the drive stop and status logic.
`ifndef DSS_DEFINES_VH
`define DSS_DEFINES_VH

// ****************************************************************
// Object indices
// ****************************************************************
`define DSS_IDX_ERROR_CODE   16'h603f
`define DSS_IDX_STATUS_WORD  16'h6041
`define DSS_IDX_QUICK_STOP   16'h605a
`define DSS_IDX_SHUTDOWN     16'h605b
`define DSS_IDX_DISABLE_OP   16'h605c
`define DSS_IDX_HALT         16'h605d

// ****************************************************************
// Reset values and permitted sets, one mask bit per code value
// ****************************************************************
`define DSS_RST_QUICK_STOP   16'h0002
`define DSS_RST_SHUTDOWN     16'h0001
`define DSS_RST_DISABLE_OP   16'h0001
`define DSS_RST_HALT         16'h0001
`define DSS_OK_QUICK_STOP    16'h00ef
`define DSS_OK_SHUTDOWN      16'h0003
`define DSS_OK_DISABLE_OP    16'h0003
`define DSS_OK_HALT          16'h000e

// ****************************************************************
// Status word fields and error code alarm tag
// ****************************************************************
`define DSS_SW_WARNING       7
`define DSS_SW_MFR_LOW       8
`define DSS_SW_REMOTE        9
`define DSS_SW_TARGET        10
`define DSS_SW_LIMIT         11
`define DSS_SW_MODE_LOW      12
`define DSS_SW_MODE_HIGH     13
`define DSS_SW_MFR_HIGH_LSB  14
`define DSS_SW_MFR_HIGH_MSB  15
`define DSS_ERR_ALARM_TAG    8'hff

// ****************************************************************
// Drive state codes presented by the state machine
// ****************************************************************
`define DSS_ST_NOT_READY     3'h0
`define DSS_ST_SW_ON_DIS     3'h1
`define DSS_ST_READY         3'h2
`define DSS_ST_SWITCHED_ON   3'h3
`define DSS_ST_OP_ENABLED    3'h4
`define DSS_ST_QS_ACTIVE     3'h5
`define DSS_ST_FAULT_REACT   3'h6
`define DSS_ST_FAULT         3'h7

// ****************************************************************
// Stop rate selection and state after stop
// ****************************************************************
`define DSS_RATE_KEEP        2'h0
`define DSS_RATE_PROFILE     2'h1
`define DSS_RATE_QUICK       2'h2
`define DSS_RATE_INSTANT     2'h3
`define DSS_END_SW_ON_DIS    3'h1
`define DSS_END_READY        3'h2
`define DSS_END_SWITCHED_ON  3'h3
`define DSS_END_OP_ENABLED   3'h4
`define DSS_END_QS_ACTIVE    3'h5

`endif

// ===== logic/dss_option_reg.v
// One option code register that refuses values outside its permitted set.
`timescale 1ns/1ps
`default_nettype none

module dss_option_reg #(
    parameter [15:0] RESET_VALUE = 16'h0001,
    parameter [15:0] VALID_MASK  = 16'h0003
) (
    input  wire        clk_sys_i,
    input  wire        rstn_i,
    input  wire        wr_i,
    input  wire [15:0] wdata_i,
    output reg  [15:0] value_o,
    output wire        reject_o
);

    wire legal;

    // Negative values land outside the low nibble and are therefore refused.
    assign legal    = (wdata_i[15:4] == 12'h000) && VALID_MASK[wdata_i[3:0]];
    assign reject_o = wr_i && !legal;

    always @(posedge clk_sys_i)
    begin
        if (!rstn_i)
            value_o <= RESET_VALUE;
        else if (wr_i && legal)
            value_o <= wdata_i;
    end

endmodule

`default_nettype wire

// ===== logic/dss_core.v
// Drive status word, error code and stop behaviour selection.
`timescale 1ns/1ps
`default_nettype none
`include "dss_defines.vh"

module dss_core (
    input  wire        clk_sys_i,
    input  wire        rstn_i,
    // Object access port.
    input  wire [15:0] obj_index_i,
    input  wire        obj_rd_i,
    input  wire        obj_wr_i,
    input  wire [15:0] obj_wdata_i,
    output reg  [15:0] obj_rdata_o,
    output reg         obj_ack_o,
    output reg         obj_err_o,
    // Drive condition inputs.
    input  wire [2:0]  drive_state_i,
    input  wire        voltage_on_i,
    input  wire        info_active_i,
    input  wire        init_done_i,
    input  wire        target_reached_i,
    input  wire        internal_limit_i,
    input  wire [1:0]  mode_bits_i,
    input  wire [2:0]  mfr_bits_i,
    input  wire        alarm_present_i,
    input  wire [7:0]  alarm_code_i,
    input  wire        fault_reset_i,
    // Stop requests and motion feedback.
    input  wire        quick_stop_req_i,
    input  wire        shutdown_req_i,
    input  wire        disable_req_i,
    input  wire        halt_i,
    input  wire        ext_stop_i,
    input  wire        standstill_i,
    // Results.
    output reg  [15:0] status_word_o,
    output reg         alarm_clear_o,
    output reg         stop_active_o,
    output reg  [1:0]  stop_rate_o,
    output reg         current_off_o,
    output reg         stop_done_o,
    output reg  [2:0]  end_state_o
);

    // ****************
    // Local states and causes
    // ****************
    localparam [2:0] S_IDLE   = 3'b001;
    localparam [2:0] S_STOP   = 3'b010;
    localparam [2:0] S_FINISH = 3'b100;

    localparam [1:0] C_QUICK = 2'h0;
    localparam [1:0] C_SHUT  = 2'h1;
    localparam [1:0] C_DIS   = 2'h2;
    localparam [1:0] C_HALT  = 2'h3;

    // ****************
    // Decoding helpers
    // ****************
    function [6:0] state_flags;
        input [2:0] st;
        input       volt;
        reg   [6:0] f;
        begin
            f = 7'h00;
            case (st)
                `DSS_ST_SW_ON_DIS:   f = 7'b1000000;
                `DSS_ST_READY:       f = 7'b0100001;
                `DSS_ST_SWITCHED_ON: f = 7'b0100011;
                `DSS_ST_OP_ENABLED:  f = 7'b0100111;
                `DSS_ST_QS_ACTIVE:   f = 7'b0000111;
                `DSS_ST_FAULT_REACT: f = 7'b0001111;
                `DSS_ST_FAULT:       f = 7'b0001000;
                default:             f = 7'h00;
            endcase
            f[4] = volt;
            state_flags = f;
        end
    endfunction

    // Rate for the profile-or-off option codes of shutdown and disable.
    function [1:0] off_or_profile;
        input [15:0] code;
        begin
            if (code[0])
                off_or_profile = `DSS_RATE_PROFILE;
            else
                off_or_profile = `DSS_RATE_INSTANT;
        end
    endfunction

    // Quick stop and halt share the profile/quick/instant encoding in code bits 1:0.
    function [1:0] rate_of;
        input [15:0] code;
        begin
            case (code[1:0])
                2'h1:    rate_of = `DSS_RATE_PROFILE;
                2'h2:    rate_of = `DSS_RATE_QUICK;
                default: rate_of = `DSS_RATE_INSTANT;
            endcase
        end
    endfunction

    // ****************
    // Option code registers
    // ****************
    wire [15:0] qs_code;
    wire [15:0] shut_code;
    wire [15:0] dis_code;
    wire [15:0] halt_code;
    wire        qs_rej;
    wire        shut_rej;
    wire        dis_rej;
    wire        halt_rej;
    wire        wr_qs;
    wire        wr_shut;
    wire        wr_dis;
    wire        wr_halt;

    assign wr_qs   = obj_wr_i && (obj_index_i == `DSS_IDX_QUICK_STOP);
    assign wr_shut = obj_wr_i && (obj_index_i == `DSS_IDX_SHUTDOWN);
    assign wr_dis  = obj_wr_i && (obj_index_i == `DSS_IDX_DISABLE_OP);
    assign wr_halt = obj_wr_i && (obj_index_i == `DSS_IDX_HALT);

    dss_option_reg #(.RESET_VALUE(`DSS_RST_QUICK_STOP), .VALID_MASK(`DSS_OK_QUICK_STOP)) u_qs (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .wr_i      (wr_qs),
        .wdata_i   (obj_wdata_i),
        .value_o   (qs_code),
        .reject_o  (qs_rej)
    );

    dss_option_reg #(.RESET_VALUE(`DSS_RST_SHUTDOWN), .VALID_MASK(`DSS_OK_SHUTDOWN)) u_shut (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .wr_i      (wr_shut),
        .wdata_i   (obj_wdata_i),
        .value_o   (shut_code),
        .reject_o  (shut_rej)
    );

    dss_option_reg #(.RESET_VALUE(`DSS_RST_DISABLE_OP), .VALID_MASK(`DSS_OK_DISABLE_OP)) u_dis (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .wr_i      (wr_dis),
        .wdata_i   (obj_wdata_i),
        .value_o   (dis_code),
        .reject_o  (dis_rej)
    );

    dss_option_reg #(.RESET_VALUE(`DSS_RST_HALT), .VALID_MASK(`DSS_OK_HALT)) u_halt (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .wr_i      (wr_halt),
        .wdata_i   (obj_wdata_i),
        .value_o   (halt_code),
        .reject_o  (halt_rej)
    );

    // ****************
    // Status word and error code
    // ****************
    reg         remote;
    reg         fault_reset_q;
    reg  [15:0] next_status;
    wire [15:0] error_code;

    always @*
    begin
        next_status = 16'h0000;
        next_status[6:0] = state_flags(drive_state_i, voltage_on_i);
        next_status[`DSS_SW_WARNING] = info_active_i;
        next_status[`DSS_SW_MFR_LOW] = mfr_bits_i[0];
        next_status[`DSS_SW_REMOTE] = remote || init_done_i;
        next_status[`DSS_SW_TARGET] = target_reached_i;
        next_status[`DSS_SW_LIMIT] = internal_limit_i;
        next_status[`DSS_SW_MODE_HIGH:`DSS_SW_MODE_LOW] = mode_bits_i;
        next_status[`DSS_SW_MFR_HIGH_MSB:`DSS_SW_MFR_HIGH_LSB] = mfr_bits_i[2:1];
    end

    assign error_code = alarm_present_i ? {`DSS_ERR_ALARM_TAG, alarm_code_i} : 16'h0000;

    always @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            remote        <= 1'b0;
            status_word_o <= 16'h0000;
            fault_reset_q <= 1'b0;
            alarm_clear_o <= 1'b0;
        end
        else
        begin
            if (init_done_i)
                remote <= 1'b1;
            status_word_o <= next_status;
            fault_reset_q <= fault_reset_i;
            // A held fault reset bit must not clear alarms that arrive later.
            alarm_clear_o <= fault_reset_i && !fault_reset_q;
        end
    end

    // ****************
    // Object access: one-cycle registered answer
    // ****************
    reg [15:0] next_rdata;
    reg        next_err;

    always @*
    begin
        next_rdata = 16'h0000;
        next_err   = 1'b0;
        case (obj_index_i)
            `DSS_IDX_ERROR_CODE:  next_err = obj_wr_i;
            `DSS_IDX_STATUS_WORD: next_err = obj_wr_i;
            `DSS_IDX_QUICK_STOP:  next_err = qs_rej;
            `DSS_IDX_SHUTDOWN:    next_err = shut_rej;
            `DSS_IDX_DISABLE_OP:  next_err = dis_rej;
            `DSS_IDX_HALT:        next_err = halt_rej;
            default:              next_err = 1'b1;
        endcase
        if (obj_rd_i)
        begin
            case (obj_index_i)
                `DSS_IDX_ERROR_CODE:  next_rdata = error_code;
                `DSS_IDX_STATUS_WORD: next_rdata = next_status;
                `DSS_IDX_QUICK_STOP:  next_rdata = qs_code;
                `DSS_IDX_SHUTDOWN:    next_rdata = shut_code;
                `DSS_IDX_DISABLE_OP:  next_rdata = dis_code;
                `DSS_IDX_HALT:        next_rdata = halt_code;
                default:              next_rdata = 16'h0000;
            endcase
        end
    end

    always @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            obj_rdata_o <= 16'h0000;
            obj_ack_o   <= 1'b0;
            obj_err_o   <= 1'b0;
        end
        else
        begin
            obj_ack_o <= obj_rd_i || obj_wr_i;
            obj_err_o <= (obj_rd_i || obj_wr_i) && next_err;
            if (obj_rd_i)
                obj_rdata_o <= next_rdata;
        end
    end

    // ****************
    // Stop sequencer
    // ****************
    reg [2:0]  state;
    reg [1:0]  cause;
    reg [15:0] code_used;
    reg        ext_held;
    reg [2:0]  next_end;

    // The quick stop code is frozen at the start so a write during the stop waits.
    always @*
    begin
        next_end = `DSS_END_OP_ENABLED;
        case (cause)
            C_QUICK:
            begin
                if (code_used[2])
                    next_end = `DSS_END_QS_ACTIVE;
                else
                    next_end = `DSS_END_SW_ON_DIS;
            end
            C_SHUT:  next_end = `DSS_END_READY;
            C_DIS:   next_end = `DSS_END_SWITCHED_ON;
            default: next_end = `DSS_END_OP_ENABLED;
        endcase
    end

    always @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            state         <= S_IDLE;
            cause         <= C_QUICK;
            code_used     <= 16'h0000;
            ext_held      <= 1'b0;
            stop_active_o <= 1'b0;
            stop_rate_o   <= `DSS_RATE_KEEP;
            current_off_o <= 1'b0;
            stop_done_o   <= 1'b0;
            end_state_o   <= `DSS_END_OP_ENABLED;
        end
        else
        begin
            stop_done_o <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    current_off_o <= 1'b0;
                    ext_held      <= ext_stop_i;
                    if (quick_stop_req_i)
                    begin
                        state         <= S_STOP;
                        cause         <= C_QUICK;
                        code_used     <= qs_code;
                        stop_active_o <= 1'b1;
                        current_off_o <= (qs_code[2:0] == 3'h0);
                        if (ext_stop_i)
                            stop_rate_o <= `DSS_RATE_KEEP;
                        else
                            stop_rate_o <= rate_of(qs_code);
                    end
                    else if (shutdown_req_i)
                    begin
                        state         <= S_STOP;
                        cause         <= C_SHUT;
                        code_used     <= shut_code;
                        stop_active_o <= 1'b1;
                        stop_rate_o   <= off_or_profile(shut_code);
                        current_off_o <= !shut_code[0];
                    end
                    else if (disable_req_i)
                    begin
                        state         <= S_STOP;
                        cause         <= C_DIS;
                        code_used     <= dis_code;
                        stop_active_o <= 1'b1;
                        stop_rate_o   <= off_or_profile(dis_code);
                        current_off_o <= !dis_code[0];
                    end
                    else if (halt_i)
                    begin
                        state         <= S_STOP;
                        cause         <= C_HALT;
                        code_used     <= halt_code;
                        stop_active_o <= 1'b1;
                        stop_rate_o   <= rate_of(halt_code);
                    end
                end
                S_STOP:
                begin
                    if (ext_stop_i)
                        ext_held <= 1'b1;
                    if (quick_stop_req_i && (cause != C_QUICK))
                    begin
                        cause     <= C_QUICK;
                        code_used <= qs_code;
                        // An instant stop already under way is never slowed down.
                        if (!ext_held && !ext_stop_i && (stop_rate_o != `DSS_RATE_INSTANT))
                            stop_rate_o <= `DSS_RATE_QUICK;
                    end
                    else if (current_off_o || standstill_i)
                    begin
                        state         <= S_FINISH;
                        stop_active_o <= 1'b0;
                        // Shutdown and disable leave the motor unexcited after standstill.
                        current_off_o <= (cause == C_SHUT) || (cause == C_DIS) || current_off_o;
                        stop_done_o   <= 1'b1;
                        end_state_o   <= next_end;
                    end
                end
                S_FINISH:
                begin
                    // Halt must be released before a new halt stop is taken.
                    if (!(cause == C_HALT && halt_i))
                        state <= S_IDLE;
                end
                default:
                begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ===== tb/dss_core_asserts.sv
// Port-level assertions for the drive stop and status core.
`timescale 1ns/1ps
`default_nettype none

module dss_core_asserts (
    input wire logic        clk_sys_i,
    input wire logic        rstn_i,
    input wire logic [15:0] obj_index_i,
    input wire logic        obj_rd_i,
    input wire logic        obj_wr_i,
    input wire logic [15:0] obj_rdata_o,
    input wire logic        obj_ack_o,
    input wire logic        obj_err_o,
    input wire logic        info_active_i,
    input wire logic        init_done_i,
    input wire logic        target_reached_i,
    input wire logic        internal_limit_i,
    input wire logic [1:0]  mode_bits_i,
    input wire logic        alarm_present_i,
    input wire logic [7:0]  alarm_code_i,
    input wire logic        fault_reset_i,
    input wire logic        quick_stop_req_i,
    input wire logic        ext_stop_i,
    input wire logic        standstill_i,
    input wire logic [15:0] status_word_o,
    input wire logic        alarm_clear_o,
    input wire logic        stop_active_o,
    input wire logic [1:0]  stop_rate_o,
    input wire logic        stop_done_o
);
    default clocking dc @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    // ********
    // Checks
    // ********
    obj_answer_a: assert property ((obj_rd_i || obj_wr_i) |=> obj_ack_o)
        else $error("no answer");
    ro_write_err_a: assert property (obj_wr_i && obj_index_i[15:2] == 14'h1810 |=> obj_err_o)
        else $error("write to read-only object accepted");
    err_code_a: assert property (obj_rd_i && obj_index_i == 16'h603f |=>
        obj_rdata_o == ($past(alarm_present_i) ? {8'hff, $past(alarm_code_i)} : 16'h0000))
        else $error("error code read wrong");
    info_bit_a: assert property ($past(rstn_i) |-> status_word_o[7] == $past(info_active_i))
        else $error("info bit wrong");
    mode_limit_a: assert property ($past(rstn_i) |-> status_word_o[13:10] ==
        {$past(mode_bits_i), $past(internal_limit_i), $past(target_reached_i)})
        else $error("mode or limit bits wrong");
    remote_latch_a: assert property ($past(rstn_i) && ($past(init_done_i) || $past(status_word_o[9]))
        |-> status_word_o[9])
        else $error("initialised bit not held");
    clear_pulse_a: assert property ($rose(fault_reset_i) |=> alarm_clear_o ##1 !alarm_clear_o)
        else $error("alarm clear pulse wrong");
    qs_switch_a: assert property (stop_active_o && stop_rate_o == 2'h1 && quick_stop_req_i
        && !ext_stop_i && !standstill_i |=> stop_rate_o == 2'h2)
        else $error("rate not switched");
    ext_keep_a: assert property (stop_active_o && stop_rate_o != 2'h2 && quick_stop_req_i
        && ext_stop_i |=> stop_rate_o != 2'h2)
        else $error("external stop rate overridden");
    done_still_a: assert property (stop_active_o && standstill_i && !quick_stop_req_i
        |=> stop_done_o && !stop_active_o)
        else $error("stop not finished");
endmodule

bind dss_core dss_core_asserts i_chk (.*);

`default_nettype wire

// ===== tb/dss_master_model.sv
// Network master model driving object accesses and control word bits.
`timescale 1ns/1ps
`default_nettype none

module dss_master_model (
    input  wire logic        clk_sys_i,
    output var  logic [15:0] obj_index_i,
    output var  logic        obj_rd_i,
    output var  logic        obj_wr_i,
    output var  logic [15:0] obj_wdata_i,
    output var  logic        fault_reset_i,
    output var  logic        quick_stop_req_i,
    output var  logic        shutdown_req_i,
    output var  logic        disable_req_i,
    output var  logic        halt_i
);
    // ********
    // Requests
    // ********
    initial
    begin
        {obj_index_i, obj_rd_i, obj_wr_i, obj_wdata_i, fault_reset_i} = '0;
        {quick_stop_req_i, shutdown_req_i, disable_req_i, halt_i} = '0;
    end

    // Released index and data lines show the inverse and both strobes go low, so a stale value is never mistaken for live data.
    task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] data);
        @(negedge clk_sys_i);
        {obj_index_i, obj_wdata_i, obj_rd_i, obj_wr_i} = {idx, data, !wr, wr};
        @(negedge clk_sys_i);
        {obj_index_i, obj_wdata_i, obj_rd_i, obj_wr_i} = {~idx, ~data, 2'b00};
    endtask

    task automatic request(input logic [2:0] kind);
        @(negedge clk_sys_i);
        {disable_req_i, shutdown_req_i, quick_stop_req_i} = kind;
        @(negedge clk_sys_i);
        {disable_req_i, shutdown_req_i, quick_stop_req_i} = 3'h0;
    endtask

    task automatic hold_halt(input logic v);
        @(negedge clk_sys_i);
        halt_i = v;
        @(negedge clk_sys_i);
    endtask

    task automatic clear_alarm();
        @(negedge clk_sys_i);
        fault_reset_i = 1'b0;
        @(negedge clk_sys_i);
        fault_reset_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
    endtask
endmodule

`default_nettype wire

// ===== tb/drive_stop_status_logic_tb_top.sv
// Self-checking bench for the drive stop and status core.
`timescale 1ns/1ps
`default_nettype none
`include "dss_defines.vh"

module drive_stop_status_logic_tb_top;
    logic        clk_sys_i, rstn_i, obj_rd_i, obj_wr_i, obj_ack_o, obj_err_o, ok, remote;
    logic [15:0] obj_index_i, obj_wdata_i, obj_rdata_o, status_word_o, sw, cur;
    logic [2:0]  drive_state_i, mfr_bits_i, end_state_o;
    logic [1:0]  mode_bits_i, stop_rate_o;
    logic [7:0]  alarm_code_i;
    logic        voltage_on_i, info_active_i, init_done_i, target_reached_i, internal_limit_i;
    logic        alarm_present_i, fault_reset_i, quick_stop_req_i, shutdown_req_i, disable_req_i;
    logic        halt_i, ext_stop_i, standstill_i, alarm_clear_o, stop_active_o, current_off_o, stop_done_o;
    logic [17:0] obj_q[$], got;
    logic [2:0]  stop_q[$];
    logic [31:0] rnd;
    integer      seed = 32'h830b;
    int          fail_count, cmp_count, pulses, i, k, v, n;
    localparam logic [6:0]  STATE_BITS [8] = '{7'h00, 7'h40, 7'h21, 7'h23, 7'h27, 7'h07, 7'h0f, 7'h08};
    localparam logic [15:0] IDX [4] = '{16'h605a, 16'h605b, 16'h605c, 16'h605d};
    localparam logic [15:0] LEGAL [4] = '{16'h00ef, 16'h0003, 16'h0003, 16'h000e};
    localparam logic [15:0] RST [4] = '{16'h0002, 16'h0001, 16'h0001, 16'h0001};

    dss_core i_dut (.*);
    dss_master_model i_master (.*);

    initial
    begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // ********
    // Helpers
    // ********
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic obj(input logic wr, input logic [15:0] idx, input logic [15:0] data, input logic err,
                       input logic [15:0] rd);
        obj_q.push_back({!wr, err, rd});
        i_master.access(wr, idx, data);
    endtask

    task automatic settle(input logic post);
        @(negedge clk_sys_i);
        standstill_i = 1'b1;
        for (n = 0; n < 20 && stop_active_o !== 1'b0; n++)
            @(negedge clk_sys_i);
        if (post)
            check("current_off", 16'(current_off_o), 16'h1);
        standstill_i = 1'b0;
        i_master.hold_halt(1'b0);
        repeat (3) @(negedge clk_sys_i);
    endtask

    task automatic stop_case(input logic [2:0] kind, input int idx, input logic [15:0] code,
                             input logic [1:0] rate, input logic [2:0] endst, input logic off);
        obj(1'b1, IDX[idx], code, 1'b0, 16'h0);
        stop_q.push_back(endst);
        if (kind == 3'h0)
            i_master.hold_halt(1'b1);
        else
            i_master.request(kind);
        check("stop_active", 16'(stop_active_o), 16'h1);
        check("current_off", 16'(current_off_o), 16'(off));
        if (!off)
            check("stop_rate", 16'(stop_rate_o), 16'(rate));
        settle((kind[1] | kind[2]) & !off);
    endtask

    task automatic report_and_stop();
        fail_count += obj_q.size() + stop_q.size();
        if (fail_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Results are paired with the oldest outstanding expectation.
    always @(negedge clk_sys_i)
    begin
        pulses += (alarm_clear_o === 1'b1);
        if (obj_ack_o === 1'b1)
        begin
            got = obj_q.size() ? obj_q.pop_front() : '1;
            check("obj_err", 16'(obj_err_o), 16'(got[16]));
            if (got[17])
                check("obj_rdata", obj_rdata_o, got[15:0]);
        end
        if (stop_done_o === 1'b1)
            check("end_state", 16'(end_state_o), 16'(stop_q.size() ? stop_q.pop_front() : 3'h0));
    end

    initial
    begin
        repeat (40000) @(posedge clk_sys_i);
        fail_count++;
        report_and_stop();
    end

    // ********
    // Scenarios
    // ********
    initial
    begin
        rstn_i = 1'b0;
        {drive_state_i, voltage_on_i, info_active_i, init_done_i, target_reached_i, internal_limit_i} = '0;
        {mode_bits_i, mfr_bits_i, alarm_present_i, alarm_code_i, ext_stop_i, standstill_i, remote} = '0;
        repeat (10) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        for (k = 0; k < 4; k++)
        begin
            cur = RST[k];
            obj(1'b0, IDX[k], 16'h0, 1'b0, cur);
            for (v = 0; v < 10; v++)
            begin
                rnd = (v < 9) ? 32'(v) : $random(seed);
                ok = (rnd[15:4] == 12'h0) && LEGAL[k][rnd[3:0]];
                obj(1'b1, IDX[k], rnd[15:0], !ok, 16'h0);
                if (ok)
                    cur = rnd[15:0];
                obj(1'b0, IDX[k], 16'h0, 1'b0, cur);
            end
        end
        for (i = 0; i < 48; i++)
        begin
            rnd = $random(seed);
            {drive_state_i, voltage_on_i, info_active_i, target_reached_i, internal_limit_i, mode_bits_i,
             mfr_bits_i, alarm_present_i, alarm_code_i} = rnd[20:0];
            init_done_i = rnd[21] & (i > 24);
            {standstill_i, ext_stop_i} = rnd[23:22];
            @(negedge clk_sys_i);
            remote = remote | init_done_i;
            sw = {mfr_bits_i[2:1], mode_bits_i, internal_limit_i, target_reached_i, remote, mfr_bits_i[0],
                  info_active_i, STATE_BITS[drive_state_i] | {2'b0, voltage_on_i, 4'h0}};
            check("status_word", status_word_o, sw);
        end
        obj(1'b0, `DSS_IDX_STATUS_WORD, 16'h0, 1'b0, sw);
        obj(1'b1, `DSS_IDX_STATUS_WORD, 16'h0, 1'b1, 16'h0);
        obj(1'b1, `DSS_IDX_ERROR_CODE, 16'h0, 1'b1, 16'h0);
        obj(1'b0, 16'h6040, 16'h0, 1'b1, 16'h0);
        for (k = 0; k < 2; k++)
        begin
            alarm_present_i = k[0];
            obj(1'b0, `DSS_IDX_ERROR_CODE, 16'h0, 1'b0, k[0] ? {8'hff, alarm_code_i} : 16'h0);
            v = pulses;
            i_master.clear_alarm();
            check("clear_pulses", 16'(pulses - v), 16'h1);
        end
        {drive_state_i, ext_stop_i, standstill_i} = 5'h10;
        for (v = 0; v < 8; v++)
            if (v != 4)
                stop_case(3'h1, 0, 16'(v), v[1:0], v[2] ? 3'h5 : 3'h1, v == 0);
        for (v = 0; v < 2; v++)
        begin
            stop_case(3'h2, 1, 16'(v), 2'h1, 3'h2, v == 0);
            stop_case(3'h4, 2, 16'(v), 2'h1, 3'h3, v == 0);
        end
        for (v = 1; v < 4; v++)
            stop_case(3'h0, 3, 16'(v), v[1:0], 3'h4, 1'b0);
        obj(1'b1, IDX[0], 16'h6, 1'b0, 16'h0);
        obj(1'b1, IDX[1], 16'h1, 1'b0, 16'h0);
        stop_q.push_back(3'h5);
        i_master.request(3'h2);
        i_master.request(3'h1);
        check("stop_rate", 16'(stop_rate_o), 16'h2);
        obj(1'b1, IDX[0], 16'h1, 1'b0, 16'h0);
        settle(1'b0);
        obj(1'b0, IDX[0], 16'h0, 1'b0, 16'h1);
        ext_stop_i = 1'b1;
        obj(1'b1, IDX[0], 16'h2, 1'b0, 16'h0);
        stop_q.push_back(3'h1);
        for (k = 0; k < 2; k++)
        begin
            i_master.request(3'h1);
            check("stop_rate", 16'(stop_rate_o), 16'h0);
        end
        settle(1'b0);
        ext_stop_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        report_and_stop();
    end
endmodule

`default_nettype wire
